/* File: logic/fhp_stage.sv */
// fir section 4 decimator followed by the first-order high-pass stage
// assumes samples arrive from same-clock logic, at least 120 cycles per output pair
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: section 4 integer taps, 2^-27 scale, two sets
// R2: pass band flat to 0.375 data rate
// R3: stop band about -135 dB above nyquist
// R4: phase bit 0 linear, 1 minimum
// R5: linear phase gives constant group delay
// R6: minimum phase gives shorter delay
// R7: same settling count for both phases
// R8: high-pass follows fir as last step
// R9: gain (2-a)/2, pole b=(1+(1-a)^2)/2
// R10: host computes corner word from frequency
// R11: example words 0337h, 019Ah give listed corners
// R12: small gain error, set by corner ratio
// R13: consumer waits for high-pass settling time
// R14: response images repeat at modulator rate multiples
// R15: corner word from high and low bytes
module fhp_stage
   import fhp_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   input  wire fhp_sample_t i_sample,
   output logic             o_in_ready,
   input  wire logic        i_phase_select_bit,
   input  wire logic [7:0]  i_highpass_corner_high_byte,
   input  wire logic [7:0]  i_highpass_corner_low_byte,
   input  wire logic        i_filter_clear,
   output var  fhp_sample_t o_result
);
   fhp_state_t                    state;
   fhp_state_t                    next_state;
   logic signed [FHP_DATA_W-1:0]  hist [0:FHP_TAPS-1];
   logic [FHP_PTR_W-1:0]          wr_ptr;
   logic [FHP_PTR_W-1:0]          rd_ptr;
   logic [FHP_PTR_W-1:0]          tap_idx;
   logic                          decim_ph;
   logic                          phase_q;
   logic signed [FHP_ACC_W-1:0]   acc;
   logic signed [FHP_DATA_W-1:0]  x_prev;
   logic signed [FHP_DATA_W+1:0]  y_prev;

   wire logic                     take      = i_sample.valid && o_in_ready;
   wire logic                     start_mac = take && decim_ph;
   wire logic                     mac_last  = (state == FHP_MAC) && (tap_idx == FHP_LAST_TAP);
   wire logic [FHP_PTR_W-1:0]     wr_next   = (wr_ptr == FHP_LAST_TAP) ? '0 : wr_ptr + 7'h1;
   wire logic [FHP_PTR_W-1:0]     rd_next   = (rd_ptr == '0) ? FHP_LAST_TAP : rd_ptr - 7'h1;
   wire logic signed [FHP_COEF_W-1:0] coef  = fhp_tap(phase_q, tap_idx);       // R1 R2 R3 R4
   wire logic signed [FHP_ACC_W-1:0]  prod  = FHP_ACC_W'(coef * hist[rd_ptr]); // R1

   // the fir result, rescaled by 2^-27
   wire logic signed [FHP_DATA_W-1:0] fir_out = FHP_DATA_W'(acc >>> FHP_TAP_SHIFT); // R1

   // corner word and derived coefficients in q16, except the square of 1 - a in q32
   wire logic [15:0] corner_word = {i_highpass_corner_high_byte,
                                    i_highpass_corner_low_byte};             // R15
   wire logic [16:0] one_m_a   = FHP_ONE_Q16 - {1'b0, corner_word};          // R15
   wire logic [33:0] one_m_a_sq = {17'h0, one_m_a} * {17'h0, one_m_a};
   wire logic [16:0] b_q16     = 17'((FHP_ONE_Q32 + one_m_a_sq) >> 17);     // R9 R11
   wire logic [16:0] g_q16     = 17'((FHP_TWO_Q16 - {2'b0, corner_word}) >> 1); // R9

   // recursion: y = g*(x - x_prev) + b*y_prev; zero at dc from the x - x_prev difference
   wire logic signed [FHP_DATA_W:0]   diff   = (FHP_DATA_W+1)'(fir_out) - (FHP_DATA_W+1)'(x_prev);
   wire logic signed [FHP_ACC_W-1:0]  ff     = FHP_ACC_W'($signed({1'b0, g_q16}) * diff);
   wire logic signed [FHP_ACC_W-1:0]  fb     = FHP_ACC_W'($signed({1'b0, b_q16}) * y_prev);
   wire logic signed [FHP_ACC_W-1:0]  hp_sum = (ff + fb) >>> FHP_HP_SHIFT;   // R8 R9
   wire logic signed [FHP_DATA_W+1:0] hp_y   = (FHP_DATA_W+2)'(hp_sum);
   wire logic signed [FHP_DATA_W-1:0] sat_max = {1'b0, {(FHP_DATA_W-1){1'b1}}};
   wire logic signed [FHP_DATA_W-1:0] sat_min = {1'b1, {(FHP_DATA_W-1){1'b0}}};
   // saturate so that a large step cannot wrap the sign
   wire logic signed [FHP_DATA_W-1:0] hp_out =
      (hp_y > (FHP_DATA_W+2)'(sat_max)) ? sat_max :
      (hp_y < (FHP_DATA_W+2)'(sat_min)) ? sat_min : FHP_DATA_W'(hp_y);

   // intake stalls while the mac walks the history, so a sample is never overwritten
   assign o_in_ready = (state == FHP_IDLE);

   always_comb begin
      next_state = state;
      case (state)
         FHP_IDLE: if (start_mac) begin
            next_state = FHP_MAC;
         end
         FHP_MAC: if (mac_last) begin
            next_state = FHP_HPF;
         end
         FHP_HPF:  next_state = FHP_IDLE;
         default:  next_state = FHP_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (take) begin
         hist[wr_ptr] <= i_sample.data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state    <= FHP_IDLE;
         wr_ptr   <= '0;
         decim_ph <= 1'b0;
      end else begin
         state <= next_state;
         if (take) begin
            wr_ptr   <= wr_next;
            decim_ph <= ~decim_ph;                                          // R14
         end
      end
   end

   // phase latched per output so one result never mixes tap sets
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_q <= 1'b0;
         rd_ptr  <= '0;
         tap_idx <= '0;
         acc     <= '0;
      end else if (start_mac) begin
         phase_q <= i_phase_select_bit;                                     // R4
         rd_ptr  <= wr_ptr;
         tap_idx <= '0;
         acc     <= '0;
      end else if (state == FHP_MAC) begin
         acc     <= acc + prod;                                             // R1 R5 R6
         rd_ptr  <= rd_next;
         tap_idx <= tap_idx + 7'h1;
      end
   end

   // high-pass history; clear lets software restart settling after a resync
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         x_prev <= '0;
         y_prev <= '0;
      end else if (i_filter_clear) begin
         x_prev <= '0;                                                      // R13
         y_prev <= '0;
      end else if (state == FHP_HPF) begin
         x_prev <= fir_out;                                                 // R8
         y_prev <= hp_y;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_result <= '0;
      end else begin
         o_result.valid <= (state == FHP_HPF);                              // R7
         if (state == FHP_HPF) begin
            o_result.data <= hp_out;                                        // R8 R12
         end
      end
   end

   a_ready_when_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
      start_mac |=> !o_in_ready ##111 o_in_ready)
      else $error("intake ready wrong around a walk");

   sequence s_mac_start;
      state == FHP_IDLE && start_mac;
   endsequence
   sequence s_mac_walk;
      ##1 (state == FHP_MAC) ##109 (state == FHP_MAC) ##1 (state == FHP_HPF);
   endsequence
   a_mac_full_length: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R7
      s_mac_start |-> s_mac_walk)
      else $error("fir walk is not 110 taps long");

   a_result_after_hpf: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R8
      state == FHP_HPF |=> o_result.valid)
      else $error("no result after high-pass step");

   a_result_one_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R8
      o_result.valid |=> !o_result.valid)
      else $error("result valid longer than one cycle");

   a_phase_held_mac: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R4
      (state == FHP_MAC && !start_mac) |=> $stable(phase_q))
      else $error("phase select changed during a walk");

   a_phase_taken: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R4
      start_mac |=> phase_q == $past(i_phase_select_bit))
      else $error("phase select not captured at walk start");

   a_pole_at_zero_word: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R9
      corner_word == 16'h0000 |-> (b_q16 == FHP_ONE_Q16 && g_q16 == FHP_ONE_Q16))
      else $error("coefficients wrong for zero corner word");

   a_corner_bytes: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R15
      one_m_a[7:0] == 8'(8'h00 - i_highpass_corner_low_byte) &&
      one_m_a[16:8] == 9'(9'h100 - {1'b0, i_highpass_corner_high_byte}
                          - {8'h00, |i_highpass_corner_low_byte}))
      else $error("corner word byte order wrong");

   a_dc_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R8
      (state == FHP_HPF && !i_filter_clear && diff == '0 && y_prev == '0)
      |=> o_result.data == '0)
      else $error("dc input leaked through high-pass");

   a_decimate_by_two: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
      (take && !decim_ph) |-> ##1 (state == FHP_IDLE))
      else $error("walk started on an odd sample");

   a_data_held: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R8
      state != FHP_HPF |=> $stable(o_result.data))
      else $error("result data changed outside a result cycle");

   a_newest_first: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
      start_mac |=> (rd_ptr == $past(wr_ptr) && tap_idx == 7'h00))
      else $error("walk does not start at the newest sample");

   a_clear_history: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R8
      i_filter_clear |=> (x_prev == '0 && y_prev == '0))
      else $error("high-pass history not cleared");

   a_walk_ends_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R7
      o_result.valid |-> o_in_ready)
      else $error("intake still stalled at result");
endmodule

`default_nettype wire

/* File: logic/fhp_pkg.sv */
// shared constants, types and tap tables for the fir section 4 and high-pass stage
// assumes one converter clock domain; configuration inputs are static between conversions
package fhp_pkg;
   localparam int          FHP_TAPS      = 110;
   localparam int          FHP_DATA_W    = 24;
   localparam int          FHP_COEF_W    = 28;
   localparam int          FHP_ACC_W     = 60;
   localparam int          FHP_TAP_SHIFT = 27;         // scale 1/134217728
   localparam int          FHP_PTR_W     = 7;
   localparam logic [6:0]  FHP_LAST_TAP  = 7'h6d;      // index 109
   localparam int          FHP_DECIM     = 2;
   localparam int          FHP_HP_SHIFT  = 16;         // corner word scale 65536
   localparam logic [16:0] FHP_ONE_Q16   = 17'h10000;
   localparam logic [17:0] FHP_TWO_Q16   = 18'h20000;
   localparam logic [33:0] FHP_ONE_Q32   = 34'h100000000;
   localparam logic [15:0] FHP_CORNER_RST = 16'h0000;

   typedef enum logic [1:0] {
      FHP_IDLE = 2'b00,
      FHP_MAC  = 2'b01,
      FHP_HPF  = 2'b10
   } fhp_state_t;

   typedef struct packed {
      logic                         valid;
      logic signed [FHP_DATA_W-1:0] data;
   } fhp_sample_t;

   // final taps of section 4; lower indices come from the coefficient table owner
   function automatic logic signed [FHP_COEF_W-1:0] fhp_tap(input logic minimum,
                                                             input logic [6:0] idx);
      logic signed [FHP_COEF_W-1:0] lin;
      logic signed [FHP_COEF_W-1:0] mph;
      lin = 28'sh0;
      mph = 28'sh0;
      case (idx)
         7'h62: begin lin =  28'sh55f8; mph = -28'sh15d; end
         7'h63: begin lin =  28'sh297c; mph = -28'sh60;  end
         7'h64: begin lin = -28'sh2058; mph =  28'sh90;  end
         7'h65: begin lin = -28'sh29a7; mph =  28'sh4e;  end
         7'h66: begin lin = -28'sh10a;  mph = -28'sh2e;  end
         7'h67: begin lin =  28'sh1cfb; mph = -28'sh2a;  end
         7'h68: begin lin =  28'sh1a24; mph =  28'sh9;   end
         7'h69: begin lin =  28'sh9b1;  mph =  28'sh10;  end
         7'h6a: begin lin = -28'sh4b;   mph =  28'sh0;   end
         7'h6b: begin lin = -28'sh1b0;  mph = -28'sh4;   end
         7'h6c: begin lin = -28'sh84;   mph =  28'sh0;   end
         default: begin lin = 28'sh0;   mph =  28'sh0;   end
      endcase
      return minimum ? mph : lin;
   endfunction
endpackage

/* File: tb/fhp_src.sv */
// behavioural modulator sample source feeding the fir/high-pass stage
// assumes the stage takes a sample on a rising edge with valid and ready both high
`timescale 1ns/1ps
`default_nettype none
module fhp_src
   import fhp_pkg::*;
(
   input  wire logic      i_ref_clk,
   input  wire logic      i_ready,
   output var fhp_sample_t o_sample
);
   initial o_sample = '0;

   // holds valid and data until taken; idle data inverted so stale values never match
   task automatic put(input logic signed [FHP_DATA_W-1:0] v);
      @(negedge i_ref_clk);
      o_sample.valid = 1'b1;
      o_sample.data  = v;
      while (i_ready !== 1'b1) @(negedge i_ref_clk);
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      o_sample.valid = 1'b0;
      o_sample.data  = ~v;
   endtask
endmodule
`default_nettype wire

/* File: tb/test_fhp_stage.sv */
// self-checking bench for the fir section 4 and high-pass stage
// assumes the stage package and a behavioural sample source beside it
`timescale 1ns/1ps
`default_nettype none
module test_fhp_stage;
   import fhp_pkg::*;
   localparam logic [23:0] AMP = 24'h7fffff;
   logic        ref_clk   = 1'b0;
   logic        reset_n   = 1'b0;
   logic        phase     = 1'b0;
   logic [7:0]  hi_byte   = 8'h00;
   logic [7:0]  lo_byte   = 8'h00;
   logic        clear     = 1'b0;
   logic        in_ready;
   fhp_sample_t sample;
   fhp_sample_t result;
   int          fails     = 0;
   int          cmp_count = 0;

   always #2.5 ref_clk = ~ref_clk;

   fhp_src i_fhp_src (.i_ref_clk(ref_clk), .i_ready(in_ready), .o_sample(sample));

   fhp_stage i_fhp_stage (
      .i_ref_clk                   (ref_clk),
      .i_reset_n                   (reset_n),
      .i_sample                    (sample),
      .o_in_ready                  (in_ready),
      .i_phase_select_bit          (phase),
      .i_highpass_corner_high_byte (hi_byte),
      .i_highpass_corner_low_byte  (lo_byte),
      .i_filter_clear              (clear),
      .o_result                    (result)
   );

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one odd/even pair, then cycles counted until the result strobe
   task automatic pair(input logic [23:0] v, output logic [23:0] y, output int n);
      i_fhp_src.put(v);
      i_fhp_src.put(v);
      n = 1;
      while (result.valid !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      y = result.data;
      chk(n[23:0], 24'd112);
   endtask

   // high-pass history clear while idle, so the next result starts from zero x_prev and y_prev
   task automatic clr();
      @(negedge ref_clk);
      clear = 1'b1;
      @(negedge ref_clk);
      clear = 1'b0;
   endtask

   task automatic t_dc(input logic ph, input logic [23:0] v, input logic [23:0] exp);
      logic [23:0] y;
      int          n;
      phase = ph;
      for (int k = 0; k < 56; k++) pair(v, y, n);
      chk(n[23:0], 24'd112);
      clr();
      pair(v, y, n);
      chk(y, exp);
      $display("dc test phase %0d done", ph);
   endtask

   task automatic t_hp(input logic [15:0] w);
      logic [23:0] y;
      int          n;
      longint      wl, g, b, xp, yp, ye;
      wl = w;
      g  = (131072 - wl) >>> 1;
      b  = (64'sd4294967296 + (65536 - wl) * (65536 - wl)) >>> 17;
      {hi_byte, lo_byte} = w;
      clr();
      xp = 0;
      yp = 0;
      for (int k = 0; k < 8; k++) begin
         pair(AMP, y, n);
         ye = (g * (1835 - xp) + b * yp) >>> 16;
         chk(y, ye[23:0]);
         xp = 1835;
         yp = ye;
      end
      $display("high-pass test word %h done", w);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge ref_clk);
      reset_n = 1'b1;
      t_dc(1'b1, AMP, -24'sd19);
      t_dc(1'b0, AMP, 24'd1835);
      t_hp(16'h0337);
      t_hp(16'h019a);
      t_dc(1'b0, 24'h000000, 24'h000000);
      test_done();
   end

   // about 21.5k cycles expected; margin of roughly 3.7 times
   initial begin
      #400000;
      fails++;
      test_done();
   end
endmodule
`default_nettype wire
